// ===== inc/dsos_pkg.sv
/*
  Shared constants and types of the drive status output selector:
  register map, field layout, function codes, reset values, carriers.
  Assumes a 32-bit AXI4-Lite register bus and 10-bit analog samples.
*/
`default_nettype none
package dsos_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_VOLT_LIM = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CURR_LIM = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IND_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Output function codes
  localparam int CODE_W = 8;
  localparam logic [CODE_W-1:0] CODE_ALARM = 8'h05;
  localparam logic [CODE_W-1:0] CODE_VOLT_WIN = 8'h1B;
  localparam logic [CODE_W-1:0] CODE_CURR_WIN = 8'h1C;
  localparam logic [CODE_W-1:0] CODE_MAJOR_FAIL = 8'h2A;
  localparam logic [CODE_W-1:0] CODE_FWD_RUN = 8'h33;
  localparam logic [CODE_W-1:0] CODE_REV_RUN = 8'h34;
  localparam logic [CODE_W-1:0] CODE_FREQ_SRC = 8'h3A;
  localparam logic [CODE_W-1:0] CODE_RUN_SRC = 8'h3B;

  ////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int FSEL_T11_LSB = 0;
  localparam int FSEL_T12_LSB = 8;
  localparam int FSEL_RELAY_LSB = 16;
  localparam int ANA_W = 10;
  localparam int LIM_MIN_LSB = 0;
  localparam int LIM_MAX_LSB = 16;
  localparam int IND_W = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_MAJOR = 1;
  localparam int IRQ_VOLT_WIN = 2;
  localparam int IRQ_CURR_WIN = 3;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [ANA_W-1:0] LIM_MIN_RST = 10'h000;
  localparam logic [ANA_W-1:0] LIM_MAX_RST = 10'h3FF;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic running;
    logic reverse;
    logic trip;
    logic major_cause;
    logic freq_cmd_src;
    logic run_cmd_src;
  } dsos_drive_t;

  typedef struct packed {
    logic [CODE_W-1:0] relay;
    logic [CODE_W-1:0] t12;
    logic [CODE_W-1:0] t11;
  } dsos_func_sel_t;

  typedef struct packed {
    logic run_cmd_source_ind;
    logic freq_cmd_source_ind;
    logic curr_in_window_ind;
    logic volt_in_window_ind;
    logic major_fail_ind;
    logic alarm_ind;
    logic rev_running_ind;
    logic fwd_running_ind;
  } dsos_ind_t;

  localparam dsos_func_sel_t FUNC_SEL_RST = '{relay: CODE_ALARM, t12: CODE_REV_RUN, t11: CODE_FWD_RUN};

endpackage
`default_nettype wire

// ===== rtl/dsos_window.sv
/*
  Window comparator: high while the sample lies within min..max inclusive.
  Assumes sample and limits come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dsos_window #(
  parameter int W = 10
) (
  // Sample and limits
  input wire logic [W-1:0] i_value,
  input wire logic [W-1:0] i_min,
  input wire logic [W-1:0] i_max,
  // Result
  output logic o_inside
);

  // Inverted limits give an empty window, never a wrapped one
  assign o_inside = (i_value >= i_min) && (i_value <= i_max);

endmodule
`default_nettype wire

// ===== rtl/dsos_top.sv
/*
  Drive status output selector: builds the drive's status indications
  and routes a selectable one to terminal 11, terminal 12 and the relay.
  Assumes drive state and analog samples come from logic on i_clk,
  and an AXI4-Lite master that keeps one read and one write in flight.
*/
// Functional notes
// RQ1 - Forward indication high while driving forward, code 51
// RQ2 - Forward indication low in reverse or stopped
// RQ3 - Reverse indication high while driving reverse, code 52
// RQ4 - Reverse indication low forward or stopped
// RQ5 - Major failure raised alongside alarm on causes
// RQ6 - Voltage window indication high inside limits
// RQ7 - Current window indication high inside limits
// RQ8 - Command source indications, codes 58 and 59
// RQ9 - Functions assignable to 11, 12, relay
// RQ10 - Outputs registered, one cycle, inactive in reset
`timescale 1ns/100ps
`default_nettype none
module dsos_top (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Drive state and analog samples
  input wire dsos_pkg::dsos_drive_t i_drive,
  input wire logic [dsos_pkg::ANA_W-1:0] i_volt_analog_in,
  input wire logic [dsos_pkg::ANA_W-1:0] i_current_analog_in,
  // Output terminals
  output logic o_term11,
  output logic o_term12,
  output logic o_relay_contact_a,
  output logic o_relay_contact_b,
  output logic o_irq,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [dsos_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [dsos_pkg::DATA_W-1:0] i_wdata,
  input wire logic [dsos_pkg::STRB_W-1:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [dsos_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [dsos_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp
);
  import dsos_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  dsos_func_sel_t func_sel;
  logic [ANA_W-1:0] volt_min, volt_max, curr_min, curr_max;
  logic [IRQ_W-1:0] irq_status, irq_mask, irq_event, irq_clear;
  dsos_ind_t ind, next_ind;
  logic volt_inside, curr_inside;
  logic aw_held, w_held, wr_en, wr_hit, rd_hit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, next_rdata, fsel_word, vlim_word, clim_word;
  logic [STRB_W-1:0] wr_strb;

  // Byte-lane merge of a write into a register image
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_val,
                                              input logic [DATA_W-1:0] new_val,
                                              input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < STRB_W; b++)
      if (strb[b])
        res[b*8 +: 8] = new_val[b*8 +: 8];
    return res;
  endfunction

  // Indication picked by a function code; unknown codes read inactive
  function automatic logic pick(input logic [CODE_W-1:0] code, input dsos_ind_t v);
    case (code)
      CODE_FWD_RUN: return v.fwd_running_ind; // RQ1
      CODE_REV_RUN: return v.rev_running_ind; // RQ3
      CODE_ALARM: return v.alarm_ind;
      CODE_MAJOR_FAIL: return v.major_fail_ind;
      CODE_VOLT_WIN: return v.volt_in_window_ind;
      CODE_CURR_WIN: return v.curr_in_window_ind;
      CODE_FREQ_SRC: return v.freq_cmd_source_ind; // RQ8
      CODE_RUN_SRC: return v.run_cmd_source_ind; // RQ8
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Window comparators
  dsos_window #(.W(ANA_W)) u_volt_win (.i_value(i_volt_analog_in), .i_min(volt_min), .i_max(volt_max),
    .o_inside(volt_inside));
  dsos_window #(.W(ANA_W)) u_curr_win (.i_value(i_current_analog_in), .i_min(curr_min), .i_max(curr_max),
    .o_inside(curr_inside));

  ////////////////////////////////////////////////////////////////////////
  // Indications
  always_comb
  begin
    next_ind.fwd_running_ind = i_drive.running && !i_drive.reverse; // RQ1 RQ2
    next_ind.rev_running_ind = i_drive.running && i_drive.reverse; // RQ3 RQ4
    next_ind.alarm_ind = i_drive.trip;
    next_ind.major_fail_ind = i_drive.trip && i_drive.major_cause; // RQ5
    next_ind.volt_in_window_ind = volt_inside; // RQ6
    next_ind.curr_in_window_ind = curr_inside; // RQ7
    next_ind.freq_cmd_source_ind = i_drive.freq_cmd_src; // RQ8
    next_ind.run_cmd_source_ind = i_drive.run_cmd_src; // RQ8
  end

  always_ff @(posedge i_clk)
    if (!i_rst_n)
      ind <= '0;
    else if (i_ce)
      ind <= next_ind;

  ////////////////////////////////////////////////////////////////////////
  // Terminal routing, taken from the fresh indication so the pin
  // moves one cycle after its cause
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_term11 <= 1'b0; // RQ10
      o_term12 <= 1'b0;
      o_relay_contact_a <= 1'b0;
      o_relay_contact_b <= 1'b0;
    end
    else if (i_ce)
    begin
      o_term11 <= pick(func_sel.t11, next_ind); // RQ9 RQ10
      o_term12 <= pick(func_sel.t12, next_ind); // RQ9
      o_relay_contact_a <= pick(func_sel.relay, next_ind); // RQ9
      o_relay_contact_b <= !pick(func_sel.relay, next_ind);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events and sticky status
  assign irq_event[IRQ_ALARM] = next_ind.alarm_ind && !ind.alarm_ind;
  assign irq_event[IRQ_MAJOR] = next_ind.major_fail_ind && !ind.major_fail_ind;
  assign irq_event[IRQ_VOLT_WIN] = next_ind.volt_in_window_ind != ind.volt_in_window_ind;
  assign irq_event[IRQ_CURR_WIN] = next_ind.curr_in_window_ind != ind.curr_in_window_ind;

  // Set wins over a write-one-to-clear in the same cycle
  assign irq_clear = (wr_en && wr_addr == ADDR_IRQ_STATUS && wr_strb[0]) ? wr_data[IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk)
    if (!i_rst_n)
      irq_status <= '0;
    else if (i_ce)
      irq_status <= (irq_status & ~irq_clear) | irq_event;

  always_ff @(posedge i_clk)
    if (!i_rst_n)
      o_irq <= 1'b0;
    else if (i_ce)
      o_irq <= |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  assign wr_en = aw_held && w_held && !o_bvalid;
  assign fsel_word = merge(DATA_W'(func_sel), wr_data, wr_strb);
  assign vlim_word = merge((DATA_W'(volt_max) << LIM_MAX_LSB) | (DATA_W'(volt_min) << LIM_MIN_LSB), wr_data, wr_strb);
  assign clim_word = merge((DATA_W'(curr_max) << LIM_MAX_LSB) | (DATA_W'(curr_min) << LIM_MIN_LSB), wr_data, wr_strb);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      func_sel <= FUNC_SEL_RST; // RQ9
      volt_min <= LIM_MIN_RST;
      volt_max <= LIM_MAX_RST;
      curr_min <= LIM_MIN_RST;
      curr_max <= LIM_MAX_RST;
      irq_mask <= IRQ_MASK_RST;
    end
    else if (i_ce && wr_en)
    begin
      case (wr_addr)
        ADDR_FUNC_SEL: func_sel <= dsos_func_sel_t'(fsel_word[$bits(dsos_func_sel_t)-1:0]); // RQ9
        ADDR_VOLT_LIM:
        begin
          volt_min <= vlim_word[LIM_MIN_LSB +: ANA_W];
          volt_max <= vlim_word[LIM_MAX_LSB +: ANA_W];
        end
        ADDR_CURR_LIM:
        begin
          curr_min <= clim_word[LIM_MIN_LSB +: ANA_W];
          curr_max <= clim_word[LIM_MAX_LSB +: ANA_W];
        end
        ADDR_IRQ_MASK:
          if (wr_strb[0])
            irq_mask <= wr_data[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels; address and data taken in either order
  assign wr_hit = (wr_addr == ADDR_FUNC_SEL) || (wr_addr == ADDR_VOLT_LIM) ||
                  (wr_addr == ADDR_CURR_LIM) || (wr_addr == ADDR_IND_STATUS) ||
                  (wr_addr == ADDR_IRQ_STATUS) || (wr_addr == ADDR_IRQ_MASK);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      aw_held <= 1'b0;
      o_awready <= 1'b0;
      wr_addr <= '0;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        o_awready <= 1'b0;
        wr_addr <= {i_awaddr[ADDR_W-1:2], 2'h0};
      end
      else if (wr_en)
        aw_held <= 1'b0;
      else if (!aw_held && !o_bvalid)
        o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      w_held <= 1'b0;
      o_wready <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else if (i_ce)
    begin
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        o_wready <= 1'b0;
        wr_data <= i_wdata;
        wr_strb <= i_wstrb;
      end
      else if (wr_en)
        w_held <= 1'b0;
      else if (!w_held && !o_bvalid)
        o_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (wr_en)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels
  always_comb
  begin
    next_rdata = '0;
    rd_hit = 1'b1;
    case ({i_araddr[ADDR_W-1:2], 2'h0})
      ADDR_FUNC_SEL: next_rdata[$bits(dsos_func_sel_t)-1:0] = func_sel;
      ADDR_VOLT_LIM:
      begin
        next_rdata[LIM_MIN_LSB +: ANA_W] = volt_min;
        next_rdata[LIM_MAX_LSB +: ANA_W] = volt_max;
      end
      ADDR_CURR_LIM:
      begin
        next_rdata[LIM_MIN_LSB +: ANA_W] = curr_min;
        next_rdata[LIM_MAX_LSB +: ANA_W] = curr_max;
      end
      ADDR_IND_STATUS: next_rdata[IND_W-1:0] = ind;
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (i_arvalid && o_arready)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= next_rdata;
        o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_rvalid && i_rready)
        o_rvalid <= 1'b0;
      else if (!o_rvalid)
        o_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== verif/dsos_load.sv
/*
  Load model on the terminals: latches what it sees each clock.
  Assumes the terminals are levels on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dsos_load (
  // Clock
  input wire logic i_clk,
  // Terminals
  input wire logic i_term11,
  input wire logic i_term12,
  input wire logic i_relay_contact_a,
  input wire logic i_relay_contact_b,
  // Latched state
  output logic [3:0] o_seen
);
  always_ff @(posedge i_clk)
    o_seen <= {i_relay_contact_b, i_relay_contact_a, i_term12, i_term11};
endmodule
`default_nettype wire

// ===== verif/dsos_chk.sv
/*
  Checker of the selector terminals against a shadow of the selection.
  Assumes write address and data are offered together with full strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module dsos_chk
  import dsos_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Drive state
  input wire dsos_pkg::dsos_drive_t i_drive,
  // Terminals
  input wire logic o_term11,
  input wire logic o_term12,
  input wire logic o_relay_contact_a,
  input wire logic o_relay_contact_b,
  // Write channels
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [dsos_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [dsos_pkg::DATA_W-1:0] i_wdata
);
  dsos_func_sel_t sel;
  dsos_drive_t drv_q;
  logic [1:0] quiet;
  logic take;
  logic calm;
  logic [1:0] e11;
  logic [1:0] e12;
  logic [1:0] erl;

  // Bit 1 set when the code is judged from drive state alone
  function automatic logic [1:0] ind_of(input logic [CODE_W-1:0] c, input dsos_drive_t d);
    case (c)
      CODE_FWD_RUN: return {1'b1, d.running & ~d.reverse};
      CODE_REV_RUN: return {1'b1, d.running & d.reverse};
      CODE_ALARM: return {1'b1, d.trip};
      CODE_MAJOR_FAIL: return {1'b1, d.trip & d.major_cause};
      CODE_FREQ_SRC: return {1'b1, d.freq_cmd_src};
      CODE_RUN_SRC: return {1'b1, d.run_cmd_src};
      CODE_VOLT_WIN, CODE_CURR_WIN: return 2'h0;
      default: return 2'h2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shadow runs a cycle early, so checks wait until it is calm
  assign take = i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr[7:2] == 6'h00;
  assign calm = quiet == 2'h3;
  assign e11 = ind_of(sel.t11, drv_q);
  assign e12 = ind_of(sel.t12, drv_q);
  assign erl = ind_of(sel.relay, drv_q);
  always_ff @(posedge i_clk)
    if (!i_rst_n)
      sel <= FUNC_SEL_RST;
    else if (take)
      sel <= i_wdata[23:0];
  always_ff @(posedge i_clk)
    if (!i_rst_n || take)
      quiet <= 2'h0;
    else if (!calm)
      quiet <= quiet + 2'h1;
  always_ff @(posedge i_clk)
    drv_q <= i_drive;

  ////////////////////////////////////////////////////////////////////////
  fwd_term_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && e11[1] |-> o_term11 == e11[0]) else $error("terminal 11 wrong");
  fwd_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && sel.t11 == CODE_FWD_RUN && (!i_drive.running || i_drive.reverse) |=> !o_term11)
    else $error("forward shown while not forward");
  rev_term_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && e12[1] |-> o_term12 == e12[0]) else $error("terminal 12 wrong");
  dir_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && sel.t11 == CODE_FWD_RUN && sel.t12 == CODE_REV_RUN |-> !(o_term11 && o_term12))
    else $error("both directions shown");
  major_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && sel.t11 == CODE_MAJOR_FAIL && sel.relay == CODE_ALARM && o_term11 |-> o_relay_contact_a)
    else $error("major failure without alarm");
  src_term_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && sel.t12 == CODE_FREQ_SRC |-> o_term12 == drv_q.freq_cmd_src) else $error("source wrong");
  relay_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && erl[1] |-> o_relay_contact_a == erl[0]) else $error("relay wrong");
  relay_inv_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_relay_contact_b != o_relay_contact_a) else $error("relay b not inverse");
  hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    calm && e11[1] && $stable(i_drive) |=> $stable(o_term11)) else $error("terminal moved");
  reset_idle_a: assert property (@(posedge i_clk)
    !i_rst_n |=> !(o_term11 || o_term12 || o_relay_contact_a || o_relay_contact_b))
    else $error("output active in reset");

  fwd_c: cover property (@(posedge i_clk) calm && sel.t11 == CODE_FWD_RUN && o_term11);
  major_c: cover property (@(posedge i_clk) calm && sel.t11 == CODE_MAJOR_FAIL && o_term11);
  relay_c: cover property (@(posedge i_clk) calm && sel.relay == CODE_RUN_SRC && o_relay_contact_a);
endmodule

bind dsos_top dsos_chk u_chk (.i_clk, .i_rst_n, .i_drive, .o_term11, .o_term12, .o_relay_contact_a,
  .o_relay_contact_b, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata);
`default_nettype wire

// ===== verif/drive_status_output_select_bench.sv
/*
  Bench of the selector: register tasks, selection sweep, interrupts, bus errors.
  Assumes the checker is bound to the top and the load model is present.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_status_output_select_bench;
  import dsos_pkg::*;
  logic clk;
  logic ce;
  logic rst_n;
  dsos_drive_t drv;
  logic [ANA_W-1:0] volt, cur;
  logic t11, t12, rca, rcb, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [3:0] seen;
  int fails;
  int samples_checked;

  dsos_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_drive(drv), .i_volt_analog_in(volt),
    .i_current_analog_in(cur), .o_term11(t11), .o_term12(t12), .o_relay_contact_a(rca),
    .o_relay_contact_b(rcb), .o_irq(irq), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_awprot(3'h0), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp));
  dsos_load u_load (.i_clk(clk), .i_term11(t11), .i_term12(t12), .i_relay_contact_a(rca),
    .i_relay_contact_b(rcb), .o_seen(seen));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang_chk(input bit done);
    if (!done)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  // Each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end
    end
    hang_chk(done);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    for (int n = 0; n < 40 && !done; n++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        {d, r} = {rdata, rresp};
        done = 1'b1;
      end
    end
    hang_chk(done);
  endtask

  function automatic logic pick(input logic [7:0] c, input logic [7:0] e);
    case (c)
      CODE_FWD_RUN: return e[0];
      CODE_REV_RUN: return e[1];
      CODE_ALARM: return e[2];
      CODE_MAJOR_FAIL: return e[3];
      CODE_VOLT_WIN: return e[4];
      CODE_CURR_WIN: return e[5];
      CODE_FREQ_SRC: return e[6];
      CODE_RUN_SRC: return e[7];
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] x;
    logic [1:0] r;
    logic [7:0] e;
    logic a;
    dsos_drive_t t;
    dsos_func_sel_t cfg [4];
    logic [9:0] lv [4];
    cfg = '{FUNC_SEL_RST, {CODE_ALARM, CODE_FREQ_SRC, CODE_MAJOR_FAIL},
      {CODE_RUN_SRC, CODE_FWD_RUN, CODE_REV_RUN}, {CODE_CURR_WIN, 8'hFF, CODE_VOLT_WIN}};
    lv = '{10'h0FF, 10'h100, 10'h200, 10'h201};
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {drv, volt, cur, awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    check({27'h0, irq, seen}, 32'h0);
    rst_n <= 1'b1;
    rd(ADDR_FUNC_SEL, x, r);
    check(x, {8'h00, FUNC_SEL_RST});
    rd(ADDR_VOLT_LIM, x, r);
    check(x, {6'h00, LIM_MAX_RST, 6'h00, LIM_MIN_RST});
    rd(ADDR_IRQ_MASK, x, r);
    check(x, 32'h0);
    // Window edges at 0x100 and 0x200, probed one step either side
    wr(ADDR_VOLT_LIM, 32'h02000100, r);
    wr(ADDR_CURR_LIM, 32'h02000100, r);
    foreach (cfg[k])
    begin
      wr(ADDR_FUNC_SEL, {8'h00, cfg[k]}, r);
      for (int d = 0; d < 64; d++)
      begin
        t = dsos_drive_t'(d[5:0]);
        e = {t.run_cmd_src, t.freq_cmd_src, lv[d[3:2]] >= 10'h100 && lv[d[3:2]] <= 10'h200,
          lv[d[1:0]] >= 10'h100 && lv[d[1:0]] <= 10'h200, t.trip & t.major_cause, t.trip,
          t.running & t.reverse, t.running & ~t.reverse};
        a = pick(cfg[k].relay, e);
        @(posedge clk);
        drv <= t;
        volt <= lv[d[1:0]];
        cur <= lv[d[3:2]];
        rd(ADDR_IND_STATUS, x, r);
        check(x, {24'h0, e});
        @(posedge clk);
        check({28'h0, seen}, {28'h0, ~a, a, pick(cfg[k].t12, e), pick(cfg[k].t11, e)});
      end
    end
    @(posedge clk);
    drv <= '0;
    wr(ADDR_IRQ_STATUS, 32'hF, r);
    rd(ADDR_IRQ_STATUS, x, r);
    check(x, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1, r);
    @(posedge clk);
    drv <= dsos_drive_t'(6'h08);
    rd(ADDR_IRQ_STATUS, x, r);
    check(x, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0, r);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1, r);
    wr(ADDR_IRQ_STATUS, 32'h1, r);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // Bus errors and a read-only target
    rd(8'h20, x, r);
    check({x[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(ADDR_IND_STATUS, 32'hFF, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_IND_STATUS, x, r);
    check(x, 32'h4);
    // Enable low freezes the terminal although the window input moves
    @(posedge clk);
    ce <= 1'b0;
    volt <= 10'h100;
    repeat (3) @(posedge clk);
    check({31'h0, t11}, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, t11}, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
